// >>> design/bpx_defines.vh
// constants for the bit processor, table read and branch core
`ifndef BPX_DEFINES_VH
`define BPX_DEFINES_VH
// timing: one machine cycle is 1000 ns, clock is 10 MHz
`define BPX_CLK_KHZ 10000
`define BPX_MCYC_NS 1000
`define BPX_MCYC_CLKS ((`BPX_MCYC_NS * `BPX_CLK_KHZ + 999999) / 1000000)
// reset values
`define BPX_STK_RST 8'h07
`define BPX_PORT_RST 8'hff
`define BPX_PC_RST 16'h0000
// special register byte addresses
`define BPX_SF_P0 8'h80
`define BPX_SF_STK 8'h81
`define BPX_SF_DPLO 8'h82
`define BPX_SF_DPHI 8'h83
`define BPX_SF_P1 8'h90
`define BPX_SF_P2 8'ha0
`define BPX_SF_P3 8'hb0
`define BPX_SF_STAT 8'hd0
`define BPX_SF_WREG 8'he0
// status word fields
`define BPX_ST_CY 7
`define BPX_ST_RS_HI 4
`define BPX_ST_RS_LO 3
// bit addresses below 80h live in bytes 20h..2fh
`define BPX_BITRAM_BASE 4'h2
// opcodes
`define BPX_OP_TBL_DP 8'h93
`define BPX_OP_TBL_PC 8'h83
`define BPX_OP_ANC 8'h82
`define BPX_OP_ANCN 8'hb0
`define BPX_OP_ORC 8'h72
`define BPX_OP_ORCN 8'ha0
`define BPX_OP_LDC 8'ha2
`define BPX_OP_STC 8'h92
`define BPX_OP_CLRC 8'hc3
`define BPX_OP_CLRB 8'hc2
`define BPX_OP_SETC 8'hd3
`define BPX_OP_SETBIT 8'hd2
`define BPX_OP_INVC 8'hb3
`define BPX_OP_INVB 8'hb2
`define BPX_OP_JOC 8'h40
`define BPX_OP_JNOC 8'h50
`define BPX_OP_JBS 8'h20
`define BPX_OP_JBCL 8'h30
`define BPX_OP_JBSC 8'h10
`define BPX_OP_SBR 8'h80
`define BPX_OP_LJ 8'h02
`define BPX_OP_LSUB 8'h12
`define BPX_OP_SUBX 8'h22
`define BPX_OP_PG_LO 4'h1
`define BPX_OP_LD_A_DIR 8'he5
`define BPX_OP_LD_A_IMM 8'h74
`define BPX_OP_LD_DP 8'h90
`define BPX_OP_ST_DIR_A 8'hf5
`define BPX_OP_LD_A_RN 8'he8
`define BPX_OP_ST_RN_A 8'hf8
`define BPX_OP_LD_A_IND 8'he6
`define BPX_OP_ST_IND_A 8'hf6
`define BPX_MASK_RN 8'hf8
`define BPX_MASK_IND 8'hfe
`endif

// >>> design/bpx_iram.v
// internal data ram with registered read data
`timescale 1ns/10ps
`default_nettype none
module bpx_iram #(
    parameter AW = 8,
    parameter DW = 8
) (
    // clock and enable
    input wire mclk,
    input wire ce,
    // single port, write and read share the address
    input wire we,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    output reg [DW-1:0] rdata_q
);

reg [DW-1:0] mem [0:(1<<AW)-1];

// read returns the old contents on a simultaneous write
always @(posedge mclk) begin
    if (ce) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end
end

endmodule // bpx_iram
`default_nettype wire

// >>> design/bpx_core.v
// bit processor, table read and branch execution core
// Function
// - table read at data pointer plus working register loads working register
// - table read based on program counter uses address of next instruction
// - table fetch from program memory strobes program_store_enable_n
// - table reads only read program memory, never write it
// - bit address 00h-7fh in lower ram, 80h-ffh in special space
// - 128 bits in lower ram, up to 128 more in special space
// - single-bit port write changes only that latch line
// - and/or/store carry take two cycles, load/clear/set/invert take one
// - carry is the one-bit accumulator with carry-only opcodes
// - every status word bit, carry included, is bit addressable
// - no exclusive-or between carry and bit, only and and or
// - branch on bit set when one, on clear when zero, two cycles
// - test-and-clear branch jumps on one and clears the bit
// - taken branch adds signed offset to next instruction address
// - relative offset is an 8-bit field of every relative branch
// - bank register operand picks one of eight in current bank
// - direct byte 0-127 is ram, 128-255 special registers
// - indirect operand uses bank register 0 or 1 as ram pointer
// - immediate operands are 8-bit or 16-bit instruction bytes
// - long jump and long call carry a full 16-bit target
// - page jump and call keep 11 bits within next instruction 2k page
`timescale 1ns/10ps
`default_nettype none
`include "bpx_defines.vh"
module bpx_core #(
    parameter integer MCYC_CLKS = `BPX_MCYC_CLKS
) (
    // clock, reset, enable
    input wire mclk,
    input wire rst,
    input wire ce,
    // program memory
    input wire [7:0] prog_rdata,
    output reg [15:0] prog_addr_q,
    output reg program_store_enable_n,
    // port output latches, port 0 in the low byte
    output reg [31:0] port_latch_q,
    // one-cycle pulse as each instruction completes
    output reg retire_q
);

localparam [6:0] ST_FET = 7'h01;
localparam [6:0] ST_FCAP = 7'h02;
localparam [6:0] ST_DEC = 7'h04;
localparam [6:0] ST_RD = 7'h08;
localparam [6:0] ST_EXE = 7'h10;
localparam [6:0] ST_TBL = 7'h20;
localparam [6:0] ST_WAIT = 7'h40;
localparam [8:0] MC1 = MCYC_CLKS[8:0];

// instruction length in bytes
function [1:0] f_len;
    input [7:0] op;
    begin
        case (op)
            `BPX_OP_JBS, `BPX_OP_JBCL, `BPX_OP_JBSC, `BPX_OP_LJ,
            `BPX_OP_LSUB, `BPX_OP_LD_DP: f_len = 2'd3;
            `BPX_OP_ANC, `BPX_OP_ANCN, `BPX_OP_ORC, `BPX_OP_ORCN,
            `BPX_OP_LDC, `BPX_OP_STC, `BPX_OP_CLRB, `BPX_OP_SETBIT,
            `BPX_OP_INVB, `BPX_OP_JOC, `BPX_OP_JNOC, `BPX_OP_SBR,
            `BPX_OP_LD_A_DIR, `BPX_OP_LD_A_IMM,
            `BPX_OP_ST_DIR_A: f_len = 2'd2;
            default: f_len = (op[3:0] == `BPX_OP_PG_LO) ? 2'd2 : 2'd1;
        endcase
    end
endfunction

// machine cycles per instruction
function f_two_mc;
    input [7:0] op;
    begin
        case (op)
            `BPX_OP_ANC, `BPX_OP_ANCN, `BPX_OP_ORC, `BPX_OP_ORCN,
            `BPX_OP_STC, `BPX_OP_JOC, `BPX_OP_JNOC, `BPX_OP_JBS,
            `BPX_OP_JBCL, `BPX_OP_JBSC, `BPX_OP_SBR, `BPX_OP_TBL_DP,
            `BPX_OP_TBL_PC, `BPX_OP_LJ, `BPX_OP_LSUB, `BPX_OP_SUBX,
            `BPX_OP_LD_DP: f_two_mc = 1'b1;
            default: f_two_mc = (op[3:0] == `BPX_OP_PG_LO);
        endcase
    end
endfunction

// opcodes that read a byte holding an addressed bit
function f_bitop;
    input [7:0] op;
    begin
        case (op)
            `BPX_OP_ANC, `BPX_OP_ANCN, `BPX_OP_ORC, `BPX_OP_ORCN,
            `BPX_OP_LDC, `BPX_OP_STC, `BPX_OP_CLRB, `BPX_OP_SETBIT,
            `BPX_OP_INVB, `BPX_OP_JBS, `BPX_OP_JBCL,
            `BPX_OP_JBSC: f_bitop = 1'b1;
            default: f_bitop = 1'b0;
        endcase
    end
endfunction

// byte that holds a bit address
function [7:0] f_bit_byte;
    input [7:0] b;
    begin
        if (b[7]) begin
            f_bit_byte = {b[7:3], 3'b000};
        end else begin
            f_bit_byte = {`BPX_BITRAM_BASE, b[6:3]};
        end
    end
endfunction

// replace one bit of a byte, others kept
function [7:0] f_put;
    input [7:0] byte_in;
    input [2:0] idx;
    input val;
    begin
        f_put = byte_in;
        f_put[idx] = val;
    end
endfunction

reg [6:0] state_q;
reg [15:0] prog_cnt_q;
reg [15:0] dp_q;
reg [7:0] wreg_q;
reg [7:0] stat_q;
reg [7:0] stk_q;
reg [7:0] op_q;
reg [7:0] b1_q;
reg [7:0] b2_q;
reg [7:0] hi_q;
reg [7:0] mem_addr_q;
reg mem_sf_q;
reg phase_q;
reg [1:0] idx_q;
reg [8:0] cnt_q;
reg [7:0] sf_rdata;
reg wr_en;
reg [7:0] wr_data;
wire [7:0] ram_rdata;

wire [1:0] bank = stat_q[`BPX_ST_RS_HI:`BPX_ST_RS_LO];
wire cy = stat_q[`BPX_ST_CY];
wire [7:0] rdata = mem_sf_q ? sf_rdata : ram_rdata;
wire bitv = rdata[b1_q[2:0]];
wire [1:0] cur_len = f_len((idx_q == 2'd0) ? prog_rdata : op_q);
wire is_pg = (op_q[3:0] == `BPX_OP_PG_LO);
wire is_call = (op_q == `BPX_OP_LSUB) | (is_pg & op_q[4]);
wire is_ind_ld = ((op_q & `BPX_MASK_IND) == `BPX_OP_LD_A_IND);
wire is_ind_st = ((op_q & `BPX_MASK_IND) == `BPX_OP_ST_IND_A);
wire is_rn_ld = ((op_q & `BPX_MASK_RN) == `BPX_OP_LD_A_RN);
wire is_rn_st = ((op_q & `BPX_MASK_RN) == `BPX_OP_ST_RN_A);
// offset is byte 2 for bit tests, byte 1 otherwise
wire [7:0] rel = f_bitop(op_q) ? b2_q : b1_q;
// counter already points past the instruction
wire [15:0] br_tgt = prog_cnt_q + {{8{rel[7]}}, rel};
wire [15:0] pg_tgt = {prog_cnt_q[15:11], op_q[7:5], b1_q};
wire [15:0] call_tgt = is_pg ? pg_tgt : {b1_q, b2_q};
wire [8:0] budget_m1 = (f_two_mc(op_q) ? {MC1[7:0], 1'b0} : MC1) - 9'd1;

// special register read; parity always follows the working register
always @* begin
    case (mem_addr_q)
        `BPX_SF_P0: sf_rdata = port_latch_q[7:0];
        `BPX_SF_P1: sf_rdata = port_latch_q[15:8];
        `BPX_SF_P2: sf_rdata = port_latch_q[23:16];
        `BPX_SF_P3: sf_rdata = port_latch_q[31:24];
        `BPX_SF_STK: sf_rdata = stk_q;
        `BPX_SF_DPLO: sf_rdata = dp_q[7:0];
        `BPX_SF_DPHI: sf_rdata = dp_q[15:8];
        `BPX_SF_STAT: sf_rdata = {stat_q[7:1], ^wreg_q};
        `BPX_SF_WREG: sf_rdata = wreg_q;
        default: sf_rdata = 8'h00;
    endcase
end

// byte write of the execute step, bit writes go through the whole byte
always @* begin
    wr_en = 1'b0;
    wr_data = rdata;
    if (state_q == ST_EXE) begin
        case (op_q)
            `BPX_OP_STC: begin
                wr_en = 1'b1;
                wr_data = f_put(rdata, b1_q[2:0], cy);
            end
            `BPX_OP_CLRB: begin
                wr_en = 1'b1;
                wr_data = f_put(rdata, b1_q[2:0], 1'b0);
            end
            `BPX_OP_SETBIT: begin
                wr_en = 1'b1;
                wr_data = f_put(rdata, b1_q[2:0], 1'b1);
            end
            `BPX_OP_INVB: begin
                wr_en = 1'b1;
                wr_data = f_put(rdata, b1_q[2:0], ~bitv);
            end
            `BPX_OP_JBSC: begin
                wr_en = bitv;
                wr_data = f_put(rdata, b1_q[2:0], 1'b0);
            end
            `BPX_OP_ST_DIR_A: begin
                wr_en = 1'b1;
                wr_data = wreg_q;
            end
            default: begin
                if (is_call) begin
                    // low byte pushed first
                    wr_en = 1'b1;
                    wr_data = phase_q ? prog_cnt_q[15:8] : prog_cnt_q[7:0];
                end else if (is_rn_st || (is_ind_st && phase_q)) begin
                    wr_en = 1'b1;
                    wr_data = wreg_q;
                end
            end
        endcase
    end
end

bpx_iram #(
    .AW(8),
    .DW(8)
) u_iram (
    .mclk(mclk),
    .ce(ce),
    .we(wr_en & ~mem_sf_q),
    .addr(mem_addr_q),
    .wdata(wr_data),
    .rdata_q(ram_rdata)
);

// sequencer: fetch, decode, operand read, execute, pad to cycle budget
always @(posedge mclk) begin
    if (rst) begin
        state_q <= ST_FET;
        prog_cnt_q <= `BPX_PC_RST;
        prog_addr_q <= `BPX_PC_RST;
        program_store_enable_n <= 1'b1;
        port_latch_q <= {4{`BPX_PORT_RST}};
        retire_q <= 1'b0;
        dp_q <= 16'h0000;
        wreg_q <= 8'h00;
        stat_q <= 8'h00;
        stk_q <= `BPX_STK_RST;
        op_q <= 8'h00;
        b1_q <= 8'h00;
        b2_q <= 8'h00;
        hi_q <= 8'h00;
        mem_addr_q <= 8'h00;
        mem_sf_q <= 1'b0;
        phase_q <= 1'b0;
        idx_q <= 2'd0;
        cnt_q <= 9'd0;
    end else if (ce) begin
        retire_q <= 1'b0;
        cnt_q <= cnt_q + 9'd1;
        // special register byte writes; one port byte per write
        if (wr_en && mem_sf_q) begin
            case (mem_addr_q)
                `BPX_SF_P0: port_latch_q[7:0] <= wr_data;
                `BPX_SF_P1: port_latch_q[15:8] <= wr_data;
                `BPX_SF_P2: port_latch_q[23:16] <= wr_data;
                `BPX_SF_P3: port_latch_q[31:24] <= wr_data;
                `BPX_SF_STK: stk_q <= wr_data;
                `BPX_SF_DPLO: dp_q[7:0] <= wr_data;
                `BPX_SF_DPHI: dp_q[15:8] <= wr_data;
                `BPX_SF_STAT: stat_q <= wr_data;
                `BPX_SF_WREG: wreg_q <= wr_data;
                default: ;
            endcase
        end
        case (state_q)
            ST_FET: begin
                prog_addr_q <= prog_cnt_q;
                program_store_enable_n <= 1'b0;
                state_q <= ST_FCAP;
            end
            ST_FCAP: begin
                // immediates come straight from instruction bytes
                program_store_enable_n <= 1'b1;
                prog_cnt_q <= prog_cnt_q + 16'd1;
                case (idx_q)
                    2'd0: op_q <= prog_rdata;
                    2'd1: b1_q <= prog_rdata;
                    default: b2_q <= prog_rdata;
                endcase
                if (idx_q + 2'd1 == cur_len) begin
                    idx_q <= 2'd0;
                    state_q <= ST_DEC;
                end else begin
                    idx_q <= idx_q + 2'd1;
                    state_q <= ST_FET;
                end
            end
            ST_DEC: begin
                phase_q <= 1'b0;
                state_q <= ST_EXE;
                mem_sf_q <= 1'b0;
                if (f_bitop(op_q)) begin
                    mem_addr_q <= f_bit_byte(b1_q);
                    mem_sf_q <= b1_q[7];
                    state_q <= ST_RD;
                end else if (op_q == `BPX_OP_LD_A_DIR ||
                             op_q == `BPX_OP_ST_DIR_A) begin
                    mem_addr_q <= b1_q;
                    mem_sf_q <= b1_q[7];
                    if (op_q == `BPX_OP_LD_A_DIR) begin
                        state_q <= ST_RD;
                    end
                end else if (op_q == `BPX_OP_TBL_DP) begin
                    // program memory has no write path here
                    prog_addr_q <= dp_q + {8'h00, wreg_q};
                    program_store_enable_n <= 1'b0;
                    state_q <= ST_TBL;
                end else if (op_q == `BPX_OP_TBL_PC) begin
                    prog_addr_q <= prog_cnt_q + {8'h00, wreg_q};
                    program_store_enable_n <= 1'b0;
                    state_q <= ST_TBL;
                end else if (is_call) begin
                    mem_addr_q <= stk_q + 8'd1;
                end else if (op_q == `BPX_OP_SUBX) begin
                    mem_addr_q <= stk_q;
                    state_q <= ST_RD;
                end else if (is_rn_ld || is_rn_st) begin
                    mem_addr_q <= {3'b000, bank, op_q[2:0]};
                    if (is_rn_ld) begin
                        state_q <= ST_RD;
                    end
                end else if (is_ind_ld || is_ind_st) begin
                    mem_addr_q <= {3'b000, bank, 2'b00, op_q[0]};
                    state_q <= ST_RD;
                end
            end
            ST_RD: begin
                state_q <= ST_EXE;
            end
            ST_TBL: begin
                wreg_q <= prog_rdata;
                program_store_enable_n <= 1'b1;
                state_q <= ST_WAIT;
            end
            ST_EXE: begin
                state_q <= ST_WAIT;
                case (op_q)
                    // only and/or forms exist, no exclusive-or
                    `BPX_OP_ANC: stat_q[`BPX_ST_CY] <= cy & bitv;
                    `BPX_OP_ANCN: stat_q[`BPX_ST_CY] <= cy & ~bitv;
                    `BPX_OP_ORC: stat_q[`BPX_ST_CY] <= cy | bitv;
                    `BPX_OP_ORCN: stat_q[`BPX_ST_CY] <= cy | ~bitv;
                    `BPX_OP_LDC: stat_q[`BPX_ST_CY] <= bitv;
                    `BPX_OP_CLRC: stat_q[`BPX_ST_CY] <= 1'b0;
                    `BPX_OP_SETC: stat_q[`BPX_ST_CY] <= 1'b1;
                    `BPX_OP_INVC: stat_q[`BPX_ST_CY] <= ~cy;
                    `BPX_OP_JOC: if (cy) prog_cnt_q <= br_tgt;
                    `BPX_OP_JNOC: if (!cy) prog_cnt_q <= br_tgt;
                    `BPX_OP_JBS: if (bitv) prog_cnt_q <= br_tgt;
                    `BPX_OP_JBCL: if (!bitv) prog_cnt_q <= br_tgt;
                    `BPX_OP_JBSC: if (bitv) prog_cnt_q <= br_tgt;
                    `BPX_OP_SBR: prog_cnt_q <= br_tgt;
                    `BPX_OP_LJ: prog_cnt_q <= {b1_q, b2_q};
                    `BPX_OP_LD_A_DIR: wreg_q <= rdata;
                    `BPX_OP_LD_A_IMM: wreg_q <= b1_q;
                    `BPX_OP_LD_DP: dp_q <= {b1_q, b2_q};
                    `BPX_OP_SUBX: begin
                        // high byte sits on top of the stack
                        if (phase_q) begin
                            prog_cnt_q <= {hi_q, rdata};
                            stk_q <= stk_q - 8'd2;
                        end else begin
                            hi_q <= rdata;
                            mem_addr_q <= stk_q - 8'd1;
                            phase_q <= 1'b1;
                            state_q <= ST_RD;
                        end
                    end
                    default: begin
                        if (is_call) begin
                            stk_q <= stk_q + 8'd1;
                            if (phase_q) begin
                                prog_cnt_q <= call_tgt;
                            end else begin
                                mem_addr_q <= stk_q + 8'd2;
                                phase_q <= 1'b1;
                                state_q <= ST_EXE;
                            end
                        end else if (is_pg) begin
                            prog_cnt_q <= pg_tgt;
                        end else if (is_rn_ld) begin
                            wreg_q <= rdata;
                        end else if ((is_ind_ld || is_ind_st) && !phase_q) begin
                            // pointer fetched, now address the target
                            mem_addr_q <= rdata;
                            phase_q <= 1'b1;
                            state_q <= is_ind_ld ? ST_RD : ST_EXE;
                        end else if (is_ind_ld) begin
                            wreg_q <= rdata;
                        end
                    end
                endcase
            end
            ST_WAIT: begin
                // pad so every instruction lasts whole machine cycles
                if (cnt_q >= budget_m1) begin
                    retire_q <= 1'b1;
                    cnt_q <= 9'd0;
                    state_q <= ST_FET;
                end
            end
            default: begin
                state_q <= ST_FET;
            end
        endcase
    end
end

endmodule // bpx_core
`default_nettype wire

// >>> dv/bpx_core_properties.sv
// port-level assertion checker for the execution core
`timescale 1ns/10ps
`default_nettype none
module bpx_core_checker #(
    parameter integer MCYC_CLKS = 10
) (
    // clock, reset, enable
    input wire mclk,
    input wire rst,
    input wire ce,
    // program memory link and outputs
    input wire [7:0] prog_rdata,
    input wire [15:0] prog_addr_q,
    input wire program_store_enable_n,
    input wire [31:0] port_latch_q,
    input wire retire_q
);
    logic [15:0] cnt_q;
    logic seen_q;
    // clocks since last retire; frozen with ce like the core
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= 16'h0000;
            seen_q <= 1'b0;
        end else if (ce && retire_q) begin
            cnt_q <= 16'h0000;
            seen_q <= 1'b1;
        end else if (ce && cnt_q != 16'hffff) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    a_strobe_one_cycle: assert property (@(posedge mclk) disable iff (rst)
        ce && !program_store_enable_n |=> program_store_enable_n)
        else $error("read strobe low longer than one cycle");
    a_retire_pulse: assert property (@(posedge mclk) disable iff (rst)
        ce && retire_q |=> !retire_q)
        else $error("retire longer than one cycle");
    a_reset_values: assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> program_store_enable_n && !retire_q
        && port_latch_q == 32'hffffffff && prog_addr_q == 16'h0000)
        else $error("outputs not at reset values");
    a_first_fetch: assert property (@(posedge mclk) disable iff (rst)
        $fell(rst) |-> ##[1:3] (!program_store_enable_n
        && prog_addr_q == 16'h0000))
        else $error("no opcode fetch at zero after reset");
    a_ce_freeze: assert property (@(posedge mclk) disable iff (rst)
        !ce |=> $stable(prog_addr_q) && $stable(port_latch_q)
        && $stable(program_store_enable_n) && $stable(retire_q))
        else $error("state moved while clock enable low");
    a_instr_min: assert property (@(posedge mclk) disable iff (rst)
        ce && retire_q && seen_q |-> cnt_q >= MCYC_CLKS - 1)
        else $error("instruction shorter than one machine cycle");
    a_instr_max: assert property (@(posedge mclk) disable iff (rst)
        seen_q |-> cnt_q <= 2 * MCYC_CLKS - 1)
        else $error("instruction longer than two machine cycles");
    a_addr_holds: assert property (@(posedge mclk) disable iff (rst)
        program_store_enable_n && !$past(rst) |-> $stable(prog_addr_q))
        else $error("address moved between reads");
endmodule // bpx_core_checker
bind bpx_core bpx_core_checker #(.MCYC_CLKS(MCYC_CLKS)) i_bpx_core_checker (
    .mclk(mclk), .rst(rst), .ce(ce), .prog_rdata(prog_rdata),
    .prog_addr_q(prog_addr_q),
    .program_store_enable_n(program_store_enable_n),
    .port_latch_q(port_latch_q), .retire_q(retire_q));
`default_nettype wire

// >>> dv/bpx_prog_mem.sv
// program memory model, answers within the strobe cycle
`timescale 1ns/10ps
`default_nettype none
module bpx_prog_mem (
    // clock
    input wire logic mclk,
    // read side
    input wire logic [15:0] addr,
    input wire logic strobe_n,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    // remember the last byte so a released bus can show its inverse
    always_ff @(posedge mclk) begin
        if (!strobe_n) begin
            last_q <= mem[addr];
        end
    end
    // read only: no write port exists, bus garbage outside strobe
    assign rdata = strobe_n ? ~last_q : mem[addr];
endmodule // bpx_prog_mem
`default_nettype wire

// >>> dv/bit_processor_table_read_branch_test.sv
// self-checking bench for the execution core
`timescale 1ns/10ps
`default_nettype none
module bit_processor_table_read_branch_test;
    localparam integer MCYC = 10;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    wire [7:0] prog_rdata;
    wire [15:0] prog_addr_q;
    wire program_store_enable_n;
    wire [31:0] port_latch_q;
    wire retire_q;
    int n_mismatch = 0;
    int n_tests = 0;
    logic seen_dp = 1'b0;
    logic seen_pc = 1'b0;
    int span;
    bpx_core #(.MCYC_CLKS(MCYC)) i_bpx_core (.mclk(mclk), .rst(rst),
        .ce(ce), .prog_rdata(prog_rdata), .prog_addr_q(prog_addr_q),
        .program_store_enable_n(program_store_enable_n),
        .port_latch_q(port_latch_q), .retire_q(retire_q));
    bpx_prog_mem i_bpx_prog_mem (.mclk(mclk), .addr(prog_addr_q),
        .strobe_n(program_store_enable_n), .rdata(prog_rdata));
    // 100 ns clock
    initial begin
        forever #50 mclk = ~mclk;
    end
    // note the table fetch addresses as they are strobed
    always @(negedge mclk) begin
        if (program_store_enable_n === 1'b0 && prog_addr_q === 16'h0105)
            seen_dp = 1'b1;
        if (program_store_enable_n === 1'b0 && prog_addr_q === 16'h000d)
            seen_pc = 1'b1;
    end
    task check(input string what, input [31:0] exp, input [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bytes taken from the low end of val, first byte at base
    task prog(input [15:0] base, input [255:0] val, input int n);
        for (int i = 0; i < n; i++)
            i_bpx_prog_mem.mem[base + i] = val[8 * (n - 1 - i) +: 8];
    endtask
    task wipe;
        for (int i = 0; i < 65536; i++)
            i_bpx_prog_mem.mem[i] = 8'h00;
    endtask
    // reset, then run until the opcode at stop is strobed
    task run_to(input [15:0] stop, input bit freeze, output int sp);
        int cyc;
        int first;
        bit done;
        @(posedge mclk) rst <= 1'b1;
        @(posedge mclk) rst <= 1'b0;
        seen_dp = 1'b0;
        seen_pc = 1'b0;
        cyc = 0;
        first = -1;
        done = 0;
        while (!done && cyc < 3000) begin
            @(negedge mclk);
            cyc++;
            if (freeze && cyc == 40) begin
                @(posedge mclk) ce <= 1'b0;
                repeat (6) @(posedge mclk);
                ce <= 1'b1;
            end
            if (program_store_enable_n === 1'b0) begin
                if (first < 0) first = cyc;
                if (prog_addr_q === stop) done = 1;
            end
        end
        sp = cyc - first;
        check("stop fetch reached", 32'h1, {31'h0, done});
    endtask
    // carry ops and single-bit port writes, total timing
    task t_bit_ops;
        wipe();
        prog(16'h0000, 216'hd3c290b291d3b09292_93a0909290c37294_b39296d3829192_97_80fe, 27);
        run_to(16'h0019, 0, span);
        check("port latches", 32'hffff35ff, port_latch_q);
        check("clocks to stop", 23 * MCYC, span);
    endtask
    // bit-test branches, status carry bit address, ce freeze
    task t_branches;
        wipe();
        prog(16'h0000, 256'hd2d74002c2905002c291209202c292309302c2941095_02c2961095_02c29780fe, 32);
        run_to(16'h001e, 1, span);
        check("port latches", 32'hffff4dff, port_latch_q);
    endtask
    // table reads, long, backward relative and page jumps
    task t_tables_jumps;
        wipe();
        prog(16'h0000, 160'h7405900100_93f59074_02838002_3c00f5a0_021234, 20);
        prog(16'h0105, 8'h5a, 1);
        prog(16'h1234, 16'h8080, 2);
        prog(16'h11b6, 16'h4100, 2);
        prog(16'h1200, 16'h80fe, 2);
        run_to(16'h1200, 0, span);
        check("port latches", 32'hff3c5aff, port_latch_q);
        check("pointer table fetch", 32'h1, {31'h0, seen_dp});
        check("counter table fetch", 32'h1, {31'h0, seen_pc});
    endtask
    // bank registers, pointer, nested calls and returns, ram bit clear
    task t_calls_regs;
        wipe();
        prog(16'h0000, 136'h7430f974c3f77400e7f5211008_00e521f5, 17);
        prog(16'h0011, 136'h90120100f5a0d2d3f8_7400e508f5b080fe, 17);
        prog(16'h0100, 48'he9f580310822, 6);
        prog(16'h0108, 24'h745a22, 3);
        run_to(16'h0020, 0, span);
        check("port latches", 32'h5a5ac230, port_latch_q);
        check("clocks to stop", 28 * MCYC, span);
    endtask
    task results;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog well beyond the four runs
    initial begin
        #(20000 * 100);
        n_mismatch++;
        results();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_bit_ops();
        t_branches();
        t_tables_jumps();
        t_calls_regs();
        results();
    end
endmodule // bit_processor_table_read_branch_test
`default_nettype wire
